// ===== design/ppcs_pkg.sv
// Shared constants for the phrase playback command sequencer and its host.
// Assumes a single 250 MHz clock in both ends.
package ppcs_pkg;
  // Clock rate and command timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BYTE_PROC_NS   = 2000;
  localparam int unsigned FETCH_PROC_NS  = 5000;
  localparam int unsigned BYTE_CYC       = (BYTE_PROC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FETCH_CYC      = (FETCH_PROC_NS * CLK_MHZ + 999) / 1000;
  // Slow tick for silence, fade and chaining window
  localparam int unsigned TICK_US        = 100;
  localparam int unsigned TICK_CYC       = TICK_US * CLK_MHZ;
  localparam int unsigned SIL_UNIT_TICKS = 10;
  localparam int unsigned CHAIN_WIN_MS   = 10;
  localparam int unsigned CHAIN_WIN_TICKS = CHAIN_WIN_MS * 1000 / TICK_US;
  // Stop fade hold per sampling-rate group, in ticks
  localparam logic [5:0]  FADE_T_G0      = 6'h1E;
  localparam logic [5:0]  FADE_T_G1      = 6'h32;
  localparam logic [5:0]  FADE_T_G2      = 6'h28;
  localparam logic [5:0]  FADE_T_G3      = 6'h1D;
  localparam logic [5:0]  FADE_T_G4      = 6'h1B;
  // Command opcodes
  localparam logic [5:0]  OP_AMODE6      = 6'h01;
  localparam logic [7:0]  OP_AMP_VOL     = 8'h08;
  localparam logic [3:0]  OP_FADR        = 4'h3;
  localparam logic [3:0]  OP_PLAY        = 4'h4;
  localparam logic [3:0]  OP_START       = 4'h5;
  localparam logic [3:0]  OP_STOP        = 4'h6;
  localparam logic [3:0]  OP_SIL_INS     = 4'h7;
  localparam logic [3:0]  OP_REP_SET     = 4'h8;
  localparam logic [3:0]  OP_REP_CLR     = 4'h9;
  localparam logic [7:0]  OP_STAT_RD     = 8'hB0;
  localparam logic [7:0]  OP_PLAY3       = 8'hC8;
  localparam logic [3:0]  VOL_0DB        = 4'h0;
  // Host register map and fields
  localparam logic [7:0]  REG_CMD        = 8'h00;
  localparam logic [7:0]  REG_STAT       = 8'h04;
  localparam logic [7:0]  REG_RDST       = 8'h08;
  localparam int unsigned CMD_LEN_LSB    = 24;
  localparam int unsigned CMD_CHAIN_BIT  = 26;
  localparam int unsigned CMD_MASK_LSB   = 28;
  localparam int unsigned STAT_PEND_BIT  = 8;
  localparam int unsigned STAT_LATE_BIT  = 9;
  // Device command engine states
  typedef enum logic [1:0] {ST_IDLE, ST_BYTE, ST_FETCH, ST_FLASH} ppcs_st_e;
endpackage

// ===== design/ppcs_if.sv
// Byte command link between host controller and playback sequencer.
// Both ends share clk; no clocking block.
`timescale 1ns/100ps
interface ppcs_if;
  logic       cmd_valid;      // Host byte strobe
  logic [7:0] cmd_byte;       // Host command byte
  logic       cmd_busy_n;     // Low while device processes
  logic [3:0] chan_busy_n;    // Per-channel busy, low active
  logic [3:0] next_cmd_ready; // Per-channel ready for next
  logic       stat_valid;     // Status byte strobe
  logic [7:0] stat_byte;      // Status read answer
  modport dev  (input cmd_valid, cmd_byte,
                output cmd_busy_n, chan_busy_n, next_cmd_ready, stat_valid, stat_byte);
  modport host (output cmd_valid, cmd_byte,
                input cmd_busy_n, chan_busy_n, next_cmd_ready, stat_valid, stat_byte);
endinterface

// ===== design/ppcs_dev.sv
// Four-channel playback command sequencer, device end of the byte link.
// Assumes flash reader and mixer on the user side, all on clk.
//
// Design decisions made in the host controller: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module ppcs_dev #(
  parameter int unsigned TICK_CYC = ppcs_pkg::TICK_CYC
) (
  input  wire logic              clk,        // System clock
  input  wire logic              rst_n,      // Async reset, low active
  ppcs_if.dev                    lnk,        // Host byte link
  output logic                   fl_req,     // Flash address read request
  output logic [11:0]            fl_phrase,  // Phrase number to look up
  input  wire logic              fl_ack,     // Flash address data valid
  input  wire logic [23:0]       fl_data,    // Phrase start address
  output logic [3:0]             play_start, // Start pulse per channel
  output logic [3:0][23:0]       play_addr,  // Phrase address per channel
  output logic [3:0]             play_stop,  // Stop pulse per channel
  input  wire logic [3:0]        play_done,  // Phrase end pulse per channel
  input  wire logic [2:0]        rate_grp,   // Sampling-rate group
  output logic [3:0]             vol_out     // Applied speaker volume
);
  if (TICK_CYC < 2) begin : g_chk
    $error("TICK_CYC must be at least 2");
  end

  ppcs_pkg::ppcs_st_e st_ff;
  logic [10:0]        cnt_ff;
  logic [1:0]         idx_ff;
  logic [7:0]         b0_ff, b1_ff, b2_ff;
  logic [3:0]         fmask_ff;
  logic [14:0]        tick_cnt_ff;
  logic               tick_ff;
  logic               fade_en_ff, damp_ff;
  logic [3:0]         av_ff;
  logic [3:0]         busy_n_ff, rdy_ff, act_ff, sil_ff, rep_ff, pend_ff, pend_sil_ff;
  logic [3:0][23:0]   pend_addr_ff;
  logic [3:0][7:0]    pend_len_ff;
  logic [3:0][11:0]   sil_cnt_ff;
  logic [3:0][5:0]    fade_cnt_ff;
  logic [3:0][11:0]   preset_ff;
  logic               stat_valid_ff;
  logic [7:0]         stat_byte_ff;

  // Bytes a command needs, from its first byte
  function automatic logic [1:0] need_len(input logic [7:0] b);
    if (b == ppcs_pkg::OP_PLAY3) return 2'd3;
    if (b[7:4] == ppcs_pkg::OP_PLAY || b[7:4] == ppcs_pkg::OP_SIL_INS) return 2'd2;
    if (b[7:4] == ppcs_pkg::OP_FADR || b == ppcs_pkg::OP_AMP_VOL) return 2'd2;
    if (b[7:2] == ppcs_pkg::OP_AMODE6) return 2'd2;
    return 2'd1;
  endfunction

  // Lowest channel of a mask
  function automatic logic [1:0] low_ch(input logic [3:0] m);
    if (m[0]) return 2'd0;
    if (m[1]) return 2'd1;
    if (m[2]) return 2'd2;
    return 2'd3;
  endfunction

  // Stop fade hold for the current rate group
  function automatic logic [5:0] fade_ticks(input logic [2:0] g);
    case (g)
      3'd1:    return ppcs_pkg::FADE_T_G1;
      3'd2:    return ppcs_pkg::FADE_T_G2;
      3'd3:    return ppcs_pkg::FADE_T_G3;
      3'd4:    return ppcs_pkg::FADE_T_G4;
      default: return ppcs_pkg::FADE_T_G0;
    endcase
  endfunction

  // Command decode from the held bytes
  logic       last_done, is_play, is_play3, is_start, is_sil, fetch_kind;
  logic [3:0] cmd_mask;
  logic [11:0] cmd_phr;
  assign last_done  = (st_ff == ppcs_pkg::ST_BYTE) && (cnt_ff == '0)
                      && (idx_ff == need_len(b0_ff) - 2'd1);
  assign is_play3   = (b0_ff == ppcs_pkg::OP_PLAY3);
  assign is_play    = (b0_ff[7:4] == ppcs_pkg::OP_PLAY);
  assign is_start   = (b0_ff[7:4] == ppcs_pkg::OP_START);
  assign is_sil     = (b0_ff[7:4] == ppcs_pkg::OP_SIL_INS);
  assign fetch_kind = is_play | is_play3 | is_start | is_sil;
  assign cmd_mask   = is_play3 ? 4'(1 << b1_ff[5:4]) :
                      (is_play ? 4'(1 << b0_ff[1:0]) : b0_ff[3:0]);
  assign cmd_phr    = is_play3 ? {b1_ff[3:0], b2_ff} : {2'b00, b0_ff[3:2], b1_ff};

  // Channel events raised by the command engine
  logic [3:0] ev_accept, ev_phrase, ev_sil, ev_stop, ev_rset, ev_rclr;
  logic       flash_hit, sil_go;
  assign flash_hit = (st_ff == ppcs_pkg::ST_FLASH) && fl_ack;
  assign sil_go    = (st_ff == ppcs_pkg::ST_FETCH) && (cnt_ff == '0) && is_sil;
  assign ev_accept = (last_done && fetch_kind) ? cmd_mask : 4'h0;
  assign ev_phrase = flash_hit ? 4'(1 << low_ch(fmask_ff)) : 4'h0;
  assign ev_sil    = sil_go ? cmd_mask : 4'h0;
  assign ev_stop   = (last_done && b0_ff[7:4] == ppcs_pkg::OP_STOP) ? b0_ff[3:0] : 4'h0;
  assign ev_rset   = (last_done && b0_ff[7:4] == ppcs_pkg::OP_REP_SET) ? b0_ff[3:0] : 4'h0;
  assign ev_rclr   = (last_done && b0_ff[7:4] == ppcs_pkg::OP_REP_CLR) ? b0_ff[3:0] : 4'h0;

  // Byte reception and fetch sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff    <= ppcs_pkg::ST_IDLE;
      cnt_ff   <= '0;
      idx_ff   <= '0;
      b0_ff    <= '0;
      b1_ff    <= '0;
      b2_ff    <= '0;
      fmask_ff <= '0;
    end else begin
      case (st_ff)
        ppcs_pkg::ST_IDLE: begin
          if (lnk.cmd_valid) begin
            case (idx_ff)
              2'd0:    b0_ff <= lnk.cmd_byte;
              2'd1:    b1_ff <= lnk.cmd_byte;
              default: b2_ff <= lnk.cmd_byte;
            endcase
            cnt_ff <= 11'(ppcs_pkg::BYTE_CYC - 1);
            st_ff  <= ppcs_pkg::ST_BYTE;
          end
        end
        ppcs_pkg::ST_BYTE: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 11'd1;
          end else if (!last_done) begin
            idx_ff <= idx_ff + 2'd1;
            st_ff  <= ppcs_pkg::ST_IDLE;
          end else if (fetch_kind) begin
            idx_ff   <= '0;
            fmask_ff <= cmd_mask;
            cnt_ff   <= 11'(ppcs_pkg::FETCH_CYC - 1);
            st_ff    <= ppcs_pkg::ST_FETCH;
          end else begin
            idx_ff <= '0;
            st_ff  <= ppcs_pkg::ST_IDLE;
          end
        end
        ppcs_pkg::ST_FETCH: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 11'd1;
          end else if (is_sil || fmask_ff == 4'h0) begin
            st_ff <= ppcs_pkg::ST_IDLE;
          end else begin
            st_ff <= ppcs_pkg::ST_FLASH;
          end
        end
        ppcs_pkg::ST_FLASH: begin
          if (fl_ack) begin
            fmask_ff <= fmask_ff & ~ev_phrase;
            if ((fmask_ff & ~ev_phrase) == 4'h0) st_ff <= ppcs_pkg::ST_IDLE;
          end
        end
        default: st_ff <= ppcs_pkg::ST_IDLE;
      endcase
    end
  end

  // Flash lookup request; start uses the channel preset
  assign fl_req         = (st_ff == ppcs_pkg::ST_FLASH);
  assign fl_phrase      = is_start ? preset_ff[low_ch(fmask_ff)] : cmd_phr;
  assign lnk.cmd_busy_n = (st_ff == ppcs_pkg::ST_IDLE);

  // Slow tick divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= (tick_cnt_ff == 15'(TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == 15'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 15'd1;
    end
  end

  // Configuration commands and status answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fade_en_ff    <= 1'b0;
      damp_ff       <= 1'b0;
      av_ff         <= ppcs_pkg::VOL_0DB;
      vol_out       <= ppcs_pkg::VOL_0DB;
      preset_ff     <= '0;
      stat_valid_ff <= 1'b0;
      stat_byte_ff  <= '0;
    end else begin
      stat_valid_ff <= 1'b0;
      if (last_done && b0_ff[7:2] == ppcs_pkg::OP_AMODE6) begin
        damp_ff    <= b0_ff[1];
        fade_en_ff <= b1_ff[7];
      end
      if (last_done && b0_ff == ppcs_pkg::OP_AMP_VOL) av_ff <= b1_ff[5:2];
      if (last_done && b0_ff[7:4] == ppcs_pkg::OP_FADR)
        preset_ff[b0_ff[1:0]] <= {2'b00, b0_ff[3:2], b1_ff};
      if (last_done && b0_ff == ppcs_pkg::OP_STAT_RD) begin
        stat_valid_ff <= 1'b1;
        stat_byte_ff  <= {busy_n_ff, rdy_ff};
      end
      vol_out <= damp_ff ? ppcs_pkg::VOL_0DB : av_ff;
    end
  end
  assign lnk.stat_valid = stat_valid_ff;
  assign lnk.stat_byte  = stat_byte_ff;

  // Per-channel playback state; later assignments win within a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_n_ff    <= '1;
      rdy_ff       <= '1;
      act_ff       <= '0;
      sil_ff       <= '0;
      rep_ff       <= '0;
      pend_ff      <= '0;
      pend_sil_ff  <= '0;
      pend_addr_ff <= '0;
      pend_len_ff  <= '0;
      sil_cnt_ff   <= '0;
      fade_cnt_ff  <= '0;
      play_start   <= '0;
      play_stop    <= '0;
      play_addr    <= '0;
    end else begin
      play_start <= '0;
      play_stop  <= '0;
      for (int i = 0; i < 4; i++) begin
        logic end_i;
        logic run_i;
        end_i = (act_ff[i] && play_done[i])
                || (sil_ff[i] && tick_ff && sil_cnt_ff[i] == '0);
        run_i = (act_ff[i] || sil_ff[i]) && !end_i;
        if (ev_stop[i]) begin
          {act_ff[i], sil_ff[i], pend_ff[i], rep_ff[i]} <= 4'h0;
          play_stop[i] <= 1'b1;
          rdy_ff[i]    <= 1'b1;
          busy_n_ff[i] <= !fade_en_ff;
          fade_cnt_ff[i] <= fade_en_ff ? fade_ticks(rate_grp) : 6'd0;
        end else begin
          if (sil_ff[i] && tick_ff && sil_cnt_ff[i] != '0)
            sil_cnt_ff[i] <= sil_cnt_ff[i] - 12'd1;
          if (fade_cnt_ff[i] != '0 && tick_ff) begin
            fade_cnt_ff[i] <= fade_cnt_ff[i] - 6'd1;
            if (fade_cnt_ff[i] == 6'd1) busy_n_ff[i] <= 1'b1;
          end
          if (end_i) begin
            if (rep_ff[i] && act_ff[i]) begin
              play_start[i] <= 1'b1;
            end else if (pend_ff[i] && pend_sil_ff[i]) begin
              {act_ff[i], sil_ff[i], pend_ff[i]} <= 3'b010;
              sil_cnt_ff[i] <= 12'((pend_len_ff[i] + 12'd1) * ppcs_pkg::SIL_UNIT_TICKS - 1);
              rdy_ff[i] <= 1'b1;
            end else if (pend_ff[i]) begin
              {act_ff[i], sil_ff[i], pend_ff[i]} <= 3'b100;
              play_addr[i]  <= pend_addr_ff[i];
              play_start[i] <= 1'b1;
              rdy_ff[i]     <= 1'b1;
            end else begin
              {act_ff[i], sil_ff[i]} <= 2'b00;
              busy_n_ff[i] <= 1'b1;
              rdy_ff[i]    <= 1'b1;
            end
          end
          if (ev_accept[i]) begin
            busy_n_ff[i]   <= 1'b0;
            rdy_ff[i]      <= 1'b0;
            fade_cnt_ff[i] <= '0;
          end
          if (ev_phrase[i] && run_i) begin
            pend_ff[i] <= 1'b1;
            pend_sil_ff[i]  <= 1'b0;
            pend_addr_ff[i] <= fl_data;
          end else if (ev_phrase[i]) begin
            {act_ff[i], sil_ff[i]} <= 2'b10;
            play_addr[i]  <= fl_data;
            play_start[i] <= 1'b1;
            rdy_ff[i]     <= 1'b1;
            busy_n_ff[i]  <= 1'b0;
          end
          if (ev_sil[i] && run_i) begin
            pend_ff[i] <= 1'b1;
            pend_sil_ff[i] <= 1'b1;
            pend_len_ff[i] <= b1_ff;
          end else if (ev_sil[i]) begin
            {act_ff[i], sil_ff[i]} <= 2'b01;
            sil_cnt_ff[i] <= 12'((b1_ff + 12'd1) * ppcs_pkg::SIL_UNIT_TICKS - 1);
            rdy_ff[i]     <= 1'b1;
            busy_n_ff[i]  <= 1'b0;
          end
          if (ev_rset[i] && act_ff[i]) begin
            rep_ff[i] <= 1'b1;
            rdy_ff[i] <= 1'b0;
          end
          if (ev_rclr[i]) begin
            rep_ff[i] <= 1'b0;
            if (run_i && !pend_ff[i]) rdy_ff[i] <= 1'b1;
          end
        end
      end
    end
  end
  assign lnk.chan_busy_n    = busy_n_ff;
  assign lnk.next_cmd_ready = rdy_ff;
endmodule

// ===== design/ppcs_host.sv
// Host controller end: takes orders over AHB-Lite, sends command bytes.
// Assumes a single AHB-Lite master on clk; slave always answers OKAY.
`timescale 1ns/100ps
module ppcs_host #(
  parameter int unsigned TICK_CYC = ppcs_pkg::TICK_CYC
) (
  input  wire logic        clk,       // System clock
  input  wire logic        rst_n,     // Async reset, low active
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write strobe
  input  wire logic [2:0]  hsize,     // Transfer size, word only
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Always ready
  output logic             hresp,     // Always OKAY
  output logic [31:0]      hrdata,    // Read data
  ppcs_if.host             lnk        // Device byte link
);
  if (TICK_CYC < 2) begin : g_chk
    $error("TICK_CYC must be at least 2");
  end

  logic        aw_ff;
  logic [7:0]  aa_ff;
  logic [31:0] cmd_ff;
  logic        pend_ff, late_ff, cv_ff;
  logic [1:0]  idx_ff;
  logic [7:0]  cb_ff, rdst_ff;
  logic [14:0] tick_cnt_ff;
  logic [7:0]  win_ff;
  logic [3:0]  mask;
  logic [1:0]  len;
  logic        chain, gate_ok, send;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign mask      = cmd_ff[ppcs_pkg::CMD_MASK_LSB +: 4];
  assign chain     = cmd_ff[ppcs_pkg::CMD_CHAIN_BIT];
  assign len       = (cmd_ff[ppcs_pkg::CMD_LEN_LSB +: 2] == 2'd0) ? 2'd1
                     : cmd_ff[ppcs_pkg::CMD_LEN_LSB +: 2];
  // First byte waits for ready (chained) or for idle channels
  assign gate_ok   = chain ? &(lnk.next_cmd_ready | ~mask)
                           : &(lnk.chan_busy_n | ~mask);
  assign send      = pend_ff && lnk.cmd_busy_n && !cv_ff
                     && (idx_ff != 2'd0 || gate_ok);

  // AHB address phase capture and registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ff  <= 1'b0;
      aa_ff  <= '0;
      hrdata <= '0;
    end else if (hready) begin
      aw_ff <= hsel && htrans[1] && hwrite && hsize == 3'd2;
      aa_ff <= haddr[7:0];
      case (haddr[7:0])
        ppcs_pkg::REG_CMD:  hrdata <= cmd_ff;
        ppcs_pkg::REG_STAT: hrdata <= {22'd0, late_ff, pend_ff,
                                       lnk.next_cmd_ready, lnk.chan_busy_n};
        ppcs_pkg::REG_RDST: hrdata <= {24'd0, rdst_ff};
        default:            hrdata <= '0;
      endcase
    end
  end

  // Command loading and byte sending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff  <= '0;
      pend_ff <= 1'b0;
      idx_ff  <= '0;
      cv_ff   <= 1'b0;
      cb_ff   <= '0;
    end else begin
      cv_ff <= send;
      if (send) begin
        cb_ff  <= cmd_ff[8 * idx_ff +: 8];
        idx_ff <= idx_ff + 2'd1;
        if (idx_ff + 2'd1 == len) begin
          pend_ff <= 1'b0;
          idx_ff  <= '0;
        end
      end else if (aw_ff && aa_ff == ppcs_pkg::REG_CMD && !pend_ff) begin
        cmd_ff  <= hwdata;
        pend_ff <= 1'b1;
      end
    end
  end
  assign lnk.cmd_valid = cv_ff;
  assign lnk.cmd_byte  = cb_ff;

  // Chain window watch; late flag is sticky, write one clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
      win_ff      <= '0;
      late_ff     <= 1'b0;
      rdst_ff     <= '0;
    end else begin
      tick_cnt_ff <= (tick_cnt_ff == 15'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 15'd1;
      if (lnk.stat_valid) rdst_ff <= lnk.stat_byte;
      if (aw_ff && aa_ff == ppcs_pkg::REG_STAT && hwdata[ppcs_pkg::STAT_LATE_BIT])
        late_ff <= 1'b0;
      if (pend_ff && chain && idx_ff == 2'd0 && gate_ok && !send) begin
        if (tick_cnt_ff == 15'(TICK_CYC - 1)) win_ff <= win_ff + 8'd1;
        if (win_ff == 8'(ppcs_pkg::CHAIN_WIN_TICKS)) late_ff <= 1'b1;
      end else begin
        win_ff <= '0;
      end
    end
  end
endmodule

// ===== bench/ppcs_chk.sv
// Checker for the byte link between host controller and sequencer.
// Assumes the plain link signals of one interface on one clock.
`timescale 1ns/100ps
module ppcs_chk (
  input wire logic       clk,            // System clock
  input wire logic       rst_n,          // Async reset, low active
  input wire logic       cmd_valid,      // Host byte strobe
  input wire logic [7:0] cmd_byte,       // Host command byte
  input wire logic       cmd_busy_n,     // Low while processing
  input wire logic [3:0] chan_busy_n,    // Channel busy, low active
  input wire logic [3:0] next_cmd_ready, // Channel ready for next
  input wire logic       stat_valid,     // Status strobe
  input wire logic [7:0] stat_byte       // Status answer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] lo_ff;
  logic [3:0]  prv_ff;
  logic        fch_ff;
  // Length of each low stretch of command-busy, and whether a channel went busy in it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_ff  <= 16'h0000;
      prv_ff <= 4'hF;
      fch_ff <= 1'b0;
    end else begin
      lo_ff  <= cmd_busy_n ? 16'h0000 : lo_ff + 16'h0001;
      prv_ff <= chan_busy_n;
      fch_ff <= !cmd_busy_n && (fch_ff || ((prv_ff & ~chan_busy_n) != 4'h0));
    end
  end
  a_byte_take: assert property (cmd_valid && cmd_busy_n |=> !cmd_busy_n)
    else $error("byte not taken");
  a_byte_gap: assert property ($rose(cmd_busy_n) |-> lo_ff >= 16'd500)
    else $error("byte time short");
  a_fetch_gap: assert property ($rose(cmd_busy_n) && fch_ff |-> lo_ff >= 16'd1750)
    else $error("fetch time short");
  a_host_gate: assert property (cmd_valid |-> cmd_busy_n)
    else $error("byte sent while busy");
  a_host_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("byte strobe too long");
  a_rdy_busy: assert property ((~next_cmd_ready & chan_busy_n) == 4'h0)
    else $error("ready low on idle channel");
  a_busy_fall: assert property ((prv_ff & ~chan_busy_n) != 4'h0 |-> !cmd_busy_n)
    else $error("busy without command");
  a_fall_rdy: assert property ((prv_ff & ~chan_busy_n & next_cmd_ready) == 4'h0)
    else $error("ready high while preparing");
  // Main scenarios reached
  cover property (cmd_valid && cmd_byte == 8'hC8);
  cover property ($rose(cmd_busy_n) && fch_ff);
  cover property (stat_valid && stat_byte == 8'hFF);
endmodule

// ===== bench/tb_top.sv
// Testbench: host and sequencer joined by the link, orders given over AHB-Lite.
// Assumes a short tick; the bench stands in for flash reader and mixer.
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, hwrite, hreadyout, fl_req, fl_ack;
  logic [31:0] haddr, hwdata, hrdata, seed, rd, r;
  logic [1:0]  htrans, rc;
  logic [2:0]  hsize, rate_grp;
  logic [11:0] fl_phrase, ph;
  logic [23:0] fl_data;
  logic [3:0]  play_start, play_stop, play_done, vol_out, av;
  logic [3:0][23:0] play_addr;
  int miscompares, total_checks, n;
  int ft[5] = '{30, 50, 40, 29, 27};
  ppcs_if lnk ();
  ppcs_host #(.TICK_CYC(20)) ppcs_host_inst (.clk(clk), .rst_n(rst_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .lnk(lnk));
  ppcs_dev #(.TICK_CYC(20)) ppcs_dev_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk),
    .fl_req(fl_req), .fl_phrase(fl_phrase), .fl_ack(fl_ack), .fl_data(fl_data),
    .play_start(play_start), .play_addr(play_addr), .play_stop(play_stop), .play_done(play_done),
    .rate_grp(rate_grp), .vol_out(vol_out));
  ppcs_chk ppcs_chk_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(lnk.cmd_valid),
    .cmd_byte(lnk.cmd_byte), .cmd_busy_n(lnk.cmd_busy_n), .chan_busy_n(lnk.chan_busy_n),
    .next_cmd_ready(lnk.next_cmd_ready), .stat_valid(lnk.stat_valid),
    .stat_byte(lnk.stat_byte));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Flash contents as the bench models them
  function automatic logic [23:0] fd(input logic [11:0] p);
    return {p, ~p};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Order a command, wait until it is sent and processed
  task automatic cmd(input logic [31:0] w);
    ahb(1'b1, ppcs_pkg::REG_CMD, w);
    do ahb(1'b0, ppcs_pkg::REG_STAT, 32'h0); while (rd[ppcs_pkg::STAT_PEND_BIT] !== 1'b0);
    repeat (3) @(posedge clk);
    do @(posedge clk); while (lnk.cmd_busy_n !== 1'b1);
  endtask
  task automatic done(input logic [1:0] c);
    play_done[c] <= 1'b1;
    @(posedge clk);
    play_done <= 4'h0;
    @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Flash reader answers after a random delay
  always @(posedge clk) begin
    fl_ack <= 1'b0;
    if (fl_req === 1'b1 && !fl_ack && (rnd() & 32'h3) == 32'h0) begin
      fl_ack <= 1'b1;
      fl_data <= fd(fl_phrase);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #360000;
    miscompares++;
    finish_test();
  end
  initial begin
    {rst_n, hwrite, haddr, hwdata, htrans, play_done, rate_grp} = '0;
    hsize = 3'b010;
    seed = 32'd45221;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Plain play on channel 0, then a chained play queued behind it
    r = rnd();
    ph = {2'b00, r[9:0]};
    cmd({8'h12, 8'h00, ph[7:0], 4'h4, ph[9:8], 2'b00});
    chk({play_start, lnk.chan_busy_n, lnk.next_cmd_ready}, 12'h1EF);
    chk(play_addr[0], fd(ph));
    cmd({8'h16, 8'h00, ~ph[7:0], 4'h4, ~ph[9:8], 2'b00});
    chk({play_start, lnk.next_cmd_ready[0]}, 5'h00);
    done(2'd0);
    chk({play_start, lnk.next_cmd_ready[0], lnk.chan_busy_n[0]}, 6'h06);
    chk(play_addr[0], fd({2'b00, ~ph[9:0]}));
    done(2'd0);
    chk(lnk.chan_busy_n, 4'hF);
    // Three-byte play, then preset phrase and start, on random channels
    repeat (3) begin
      r = rnd();
      rc = r[13:12];
      ph = r[11:0];
      cmd({4'b0001 << rc, 4'h3, ph[7:0], 2'b00, rc, ph[11:8], 8'hC8});
      chk({play_start, lnk.chan_busy_n}, {4'b0001 << rc, ~(4'b0001 << rc)});
      chk(play_addr[rc], fd(ph));
      done(rc);
      cmd({8'h02, 8'h00, ph[7:0], 4'h3, ph[9:8], rc});
      cmd({4'b0001 << rc, 4'h1, 16'h0000, 4'h5, 4'b0001 << rc});
      chk(play_addr[rc], fd({2'b00, ph[9:0]}));
      done(rc);
    end
    // Volume applies with class AB only; fading stays on
    av = r[3:0];
    cmd(32'h0200_8004);
    cmd({16'h0200, 2'b00, av, 2'b00, 8'h08});
    @(posedge clk);
    chk(vol_out, av);
    cmd(32'h0200_8006);
    @(posedge clk);
    chk(vol_out, ppcs_pkg::VOL_0DB);
    // Fading stop holds busy per rate group
    for (int g = 0; g < 5; g++) begin
      rate_grp <= 3'(g);
      cmd({8'h12, 8'h00, ph[7:0], 4'h4, ph[9:8], 2'b00});
      cmd(32'h1500_0061);
      chk(play_stop, 4'h1);
      n = 0;
      while (lnk.chan_busy_n[0] !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      chk(n >= ft[g] * 20 - 25 && n <= ft[g] * 20 + 25, 1'b1);
    end
    // Silence queued behind a phrase on channel 1
    cmd({8'h22, 8'h00, ph[7:0], 4'h4, ph[9:8], 2'b01});
    cmd(32'h2600_0072);
    chk(lnk.next_cmd_ready[1], 1'b0);
    done(2'd1);
    chk({lnk.next_cmd_ready[1], lnk.chan_busy_n[1]}, 2'b10);
    repeat (175) @(posedge clk);
    chk(lnk.chan_busy_n[1], 1'b0);
    repeat (30) @(posedge clk);
    chk(lnk.chan_busy_n[1], 1'b1);
    // Repeat set while playing on channel 2, then cleared
    cmd({8'h42, 8'h00, ph[7:0], 4'h4, ph[9:8], 2'b10});
    cmd(32'h4500_0084);
    chk(lnk.next_cmd_ready[2], 1'b0);
    done(2'd2);
    chk({play_start, lnk.chan_busy_n[2]}, 5'h08);
    cmd(32'h0100_0094);
    chk(lnk.next_cmd_ready[2], 1'b1);
    done(2'd2);
    chk(lnk.chan_busy_n[2], 1'b1);
    // Status read lands in its register; unmapped address reads zero
    cmd(32'h0100_00B0);
    repeat (2) @(posedge clk);
    ahb(1'b0, ppcs_pkg::REG_RDST, 32'h0);
    chk(rd[7:0], 8'hFF);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0000_0000);
    finish_test();
  end
endmodule
